/* File: tmc_defines.vh */
// Register offsets, field positions, codes and reset values of the timer channel block
`ifndef TMC_DEFINES_VH
`define TMC_DEFINES_VH

// Global register byte offsets
`define TMC_OFF_GCTRL 11'h000
`define TMC_OFF_TB1 11'h004
`define TMC_OFF_TB2 11'h008
// Channel window: base + channel * stride, word offsets inside the window
`define TMC_CH_BASE 11'h400
`define TMC_CH_STRIDE_LOG2 5
`define TMC_CW_CTRL 3'h0
`define TMC_CW_MATCH_A 3'h1
`define TMC_CW_MATCH_B 3'h2
`define TMC_CW_CAPT_A 3'h3
`define TMC_CW_CAPT_B 3'h4
`define TMC_CW_STAT 3'h5

// Global control fields
`define TMC_GC_PRE1_LSB 0
`define TMC_GC_PRE2_LSB 8
`define TMC_GC_SRC2_LSB 16
`define TMC_GC_RUN 18
`define TMC_GCTRL_RST 19'h40000

// Second counter source codes
`define TMC_SRC_PRESCALED 2'h0
`define TMC_SRC_EXTERNAL 2'h1
`define TMC_SRC_ANGLE 2'h2

// Channel control fields
`define TMC_CC_MODE_LSB 0
`define TMC_CC_TBSEL_A 4
`define TMC_CC_TBSEL_B 5
`define TMC_CC_ACT_A_LSB 6
`define TMC_CC_ACT_B_LSB 8
`define TMC_CC_EDGE_A 10
`define TMC_CC_EDGE_B 11
`define TMC_CC_MEN_A 12
`define TMC_CC_MEN_B 13
`define TMC_CC_FORCE_LSB 14
`define TMC_CCTRL_RST 14'h0000

// Channel status fields; writing one to the service bit clears and rearms
`define TMC_ST_SVC 0
`define TMC_ST_FLAG_A 1
`define TMC_ST_FLAG_B 2
`define TMC_ST_PIN 3
`define TMC_ST_ARM_A 4
`define TMC_ST_ARM_B 5

// Pin action codes
`define TMC_ACT_NONE 2'h0
`define TMC_ACT_HIGH 2'h1
`define TMC_ACT_LOW 2'h2
`define TMC_ACT_TOGGLE 2'h3

// Channel modes
`define TMC_MODE_SINGLE_MATCH_SINGLE_EDGE 4'h0
`define TMC_MODE_INTERLOCKED_SINGLE_MATCH 4'h1
`define TMC_MODE_EITHER_MATCH_BLOCK_SINGLE 4'h2
`define TMC_MODE_EITHER_MATCH_BLOCK_DOUBLE 4'h3
`define TMC_MODE_EITHER_MATCH_NONBLOCK_SINGLE 4'h4
`define TMC_MODE_EITHER_MATCH_NONBLOCK_DOUBLE 4'h5
`define TMC_MODE_BOTH_MATCH_SINGLE 4'h6
`define TMC_MODE_BOTH_MATCH_DOUBLE 4'h7
`define TMC_MODE_BOTH_MATCH_ORDERED_SINGLE 4'h8
`define TMC_MODE_BOTH_MATCH_ORDERED_DOUBLE 4'h9
`define TMC_MODE_MATCH_TWO_SINGLE 4'hA
`define TMC_MODE_MATCH_TWO_DOUBLE 4'hB
`define TMC_MODE_SINGLE_MATCH_DOUBLE_EDGE 4'hC

`endif

/* File: tmc_time_base.v */
// Shared 24-bit time-base counter with prescaler and alternate tick sources
`timescale 1ns/100ps
`include "tmc_defines.vh"

module tmc_time_base #(
    parameter CNT_W = 24,
    parameter PRE_W = 8
) (
    input wire mclk_i,
    input wire sys_rst_i,
    input wire run_i,
    input wire [PRE_W-1:0] prescale_i,
    input wire [1:0] src_sel_i,
    input wire ext_src_i,
    input wire angle_tick_i,
    output reg [CNT_W-1:0] count_o,
    output reg tick_o
);

    reg [PRE_W-1:0] div;
    reg ext_s1;
    reg ext_s2;
    reg ext_s3;
    wire pre_req;
    wire ext_edge;
    reg req;

    // External source is asynchronous, so it passes two flops first
    always @(posedge mclk_i) begin
        if (sys_rst_i) begin
            ext_s1 <= 1'b0;
            ext_s2 <= 1'b0;
            ext_s3 <= 1'b0;
        end else begin
            ext_s1 <= ext_src_i;
            ext_s2 <= ext_s1;
            ext_s3 <= ext_s2;
        end
    end

    assign ext_edge = ext_s2 & ~ext_s3;
    assign pre_req = (div == prescale_i);

    // Tick request from the selected source
    always @* begin
        case (src_sel_i)
            `TMC_SRC_EXTERNAL: req = ext_edge;
            `TMC_SRC_ANGLE: req = angle_tick_i;
            default: req = pre_req;
        endcase
    end

    // Prescaler divider, free running while enabled
    always @(posedge mclk_i) begin
        if (sys_rst_i || !run_i || pre_req) begin
            div <= {PRE_W{1'b0}};
        end else begin
            div <= div + 1'b1;
        end
    end

    // No two ticks in a row: at most one step per two clocks
    // Counter wraps freely over the full range
    always @(posedge mclk_i) begin
        if (sys_rst_i) begin
            count_o <= {CNT_W{1'b0}};
            tick_o <= 1'b0;
        end else if (run_i && req && !tick_o) begin
            count_o <= count_o + 1'b1;
            tick_o <= 1'b1;
        end else begin
            tick_o <= 1'b0;
        end
    end

endmodule // tmc_time_base

/* File: tmc_wb_slave.v */
// Classic Wishbone slave front end: registered acknowledge and read data
`timescale 1ns/100ps

module tmc_wb_slave #(
    parameter AW = 11
) (
    input wire mclk_i,
    input wire sys_rst_i,
    input wire wb_cyc_i,
    input wire wb_stb_i,
    input wire wb_we_i,
    input wire [AW-1:0] wb_adr_i,
    input wire [31:0] rd_data_i,
    output reg [31:0] wb_dat_o,
    output reg wb_ack_o,
    output wire wr_stb_o,
    output wire [AW-1:0] adr_o
);

    wire req;

    assign req = wb_cyc_i & wb_stb_i;
    // Write lands on the edge where the master samples ack
    assign wr_stb_o = req & wb_we_i & wb_ack_o;
    assign adr_o = wb_adr_i;

    // One wait cycle, ack drops the cycle after it was given
    always @(posedge mclk_i) begin
        if (sys_rst_i) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h00000000;
        end else begin
            wb_ack_o <= req & ~wb_ack_o;
            if (req && !wb_ack_o && !wb_we_i) begin
                wb_dat_o <= rd_data_i;
            end
        end
    end

endmodule // tmc_wb_slave

/* File: tmc_channels.v */
// Timer channel array with match/capture units, mode logic and register file
`timescale 1ns/100ps
`include "tmc_defines.vh"

// Behaviour
// - Up to 32 channels, each with input, output, two units, each unit on one of two counters.
// - Output can go high, low or toggle, immediately or on a counter match.
// - Match values are 24 bits and compared in full against the counter.
// - A counter steps at most once every two system clocks.
// - Counters are 24 bits, prescalable, and wrap freely.
// - Two units on adjacent ticks give a pulse of two system clocks minimum.
// - Second counter can step from an external source or the angle clock.
// - All channels share the same two counters.
// - Only two action units; a third edge waits until the engine rearms.
// - Thirteen selectable channel modes govern matches, edges and service requests.
// - Single-match mode: one match gives one transition and one service request.
// - Either-match modes: each match acts independently and can request service.
// - Blocking variant: first match stops the second; non-blocking does not.
// - Both-match modes request service only after both matches.
// - Ordered both-match: second unit is ignored until the first has matched.
// - Match-two: first match only enables the second, which then blocks the first.
// - Either-match single variants request after first transition, non-blocking double after the second, blocking double never;
//   both-match, ordered and match-two single/double pairs act alike.
// - The pin action on a match can be disabled for input-only use.
// - Interlocked mode: a pin transition is allowed only after a match.
// - A transition requests service; the engine then programs the next match.
module tmc_channels #(
    parameter NCH = 32,
    parameter CNT_W = 24,
    parameter PRE_W = 8,
    parameter AW = 11
) (
    input wire mclk_i,
    input wire sys_rst_i,
    input wire wb_cyc_i,
    input wire wb_stb_i,
    input wire wb_we_i,
    input wire [AW-1:0] wb_adr_i,
    input wire [3:0] wb_sel_i,
    input wire [31:0] wb_dat_i,
    output wire [31:0] wb_dat_o,
    output wire wb_ack_o,
    input wire [NCH-1:0] ch_in_i,
    input wire tb2_ext_i,
    input wire angle_tick_i,
    output wire [NCH-1:0] ch_out_o,
    output wire [NCH-1:0] svc_req_o
);

    // Mode flags: {interlock, need_both, match_two, ordered, blocking, single}
    function [5:0] tmc_mode_info;
        input [3:0] mode;
        begin
            case (mode)
                `TMC_MODE_SINGLE_MATCH_SINGLE_EDGE: tmc_mode_info = 6'h01;
                `TMC_MODE_INTERLOCKED_SINGLE_MATCH: tmc_mode_info = 6'h21;
                `TMC_MODE_EITHER_MATCH_BLOCK_SINGLE: tmc_mode_info = 6'h02;
                `TMC_MODE_EITHER_MATCH_BLOCK_DOUBLE: tmc_mode_info = 6'h12;
                `TMC_MODE_EITHER_MATCH_NONBLOCK_SINGLE: tmc_mode_info = 6'h00;
                `TMC_MODE_EITHER_MATCH_NONBLOCK_DOUBLE: tmc_mode_info = 6'h10;
                `TMC_MODE_BOTH_MATCH_SINGLE: tmc_mode_info = 6'h10;
                `TMC_MODE_BOTH_MATCH_DOUBLE: tmc_mode_info = 6'h10;
                `TMC_MODE_BOTH_MATCH_ORDERED_SINGLE: tmc_mode_info = 6'h14;
                `TMC_MODE_BOTH_MATCH_ORDERED_DOUBLE: tmc_mode_info = 6'h14;
                `TMC_MODE_MATCH_TWO_SINGLE: tmc_mode_info = 6'h08;
                `TMC_MODE_MATCH_TWO_DOUBLE: tmc_mode_info = 6'h18;
                `TMC_MODE_SINGLE_MATCH_DOUBLE_EDGE: tmc_mode_info = 6'h10;
                default: tmc_mode_info = 6'h01;
            endcase
        end
    endfunction

    // Pin level after an action code
    function tmc_apply;
        input pin;
        input [1:0] act;
        begin
            case (act)
                `TMC_ACT_HIGH: tmc_apply = 1'b1;
                `TMC_ACT_LOW: tmc_apply = 1'b0;
                `TMC_ACT_TOGGLE: tmc_apply = ~pin;
                default: tmc_apply = pin;
            endcase
        end
    endfunction

    // Byte-lane merge of a write into a 32-bit view
    function [31:0] tmc_merge;
        input [31:0] old;
        input [31:0] wdat;
        input [3:0] sel;
        integer i;
        begin
            for (i = 0; i < 4; i = i + 1) begin
                tmc_merge[i*8 +: 8] = sel[i] ? wdat[i*8 +: 8] : old[i*8 +: 8];
            end
        end
    endfunction

    wire wr_stb;
    wire [AW-1:0] adr;
    reg [31:0] rd_data;
    reg [18:0] gctrl;
    wire [CNT_W-1:0] tb1;
    wire [CNT_W-1:0] tb2;
    wire tick1;
    wire tick2;
    wire [NCH*14-1:0] all_ctrl;
    wire [NCH*CNT_W-1:0] all_mat_a;
    wire [NCH*CNT_W-1:0] all_mat_b;
    wire [NCH*CNT_W-1:0] all_cap_a;
    wire [NCH*CNT_W-1:0] all_cap_b;
    wire [NCH*6-1:0] all_stat;
    wire ch_hit;
    wire [4:0] ch_idx;
    wire [2:0] ch_word;
    wire [31:0] gctrl_m;

    // Bus front end
    tmc_wb_slave #(.AW(AW)) u_bus (
        .mclk_i(mclk_i),
        .sys_rst_i(sys_rst_i),
        .wb_cyc_i(wb_cyc_i),
        .wb_stb_i(wb_stb_i),
        .wb_we_i(wb_we_i),
        .wb_adr_i(wb_adr_i),
        .rd_data_i(rd_data),
        .wb_dat_o(wb_dat_o),
        .wb_ack_o(wb_ack_o),
        .wr_stb_o(wr_stb),
        .adr_o(adr)
    );

    // Two counters shared by every channel
    tmc_time_base #(.CNT_W(CNT_W), .PRE_W(PRE_W)) u_tb1 (
        .mclk_i(mclk_i),
        .sys_rst_i(sys_rst_i),
        .run_i(gctrl[`TMC_GC_RUN]),
        .prescale_i(gctrl[`TMC_GC_PRE1_LSB +: PRE_W]),
        .src_sel_i(`TMC_SRC_PRESCALED),
        .ext_src_i(1'b0),
        .angle_tick_i(1'b0),
        .count_o(tb1),
        .tick_o(tick1)
    );

    // Second counter may step from outside or from angle logic
    tmc_time_base #(.CNT_W(CNT_W), .PRE_W(PRE_W)) u_tb2 (
        .mclk_i(mclk_i),
        .sys_rst_i(sys_rst_i),
        .run_i(gctrl[`TMC_GC_RUN]),
        .prescale_i(gctrl[`TMC_GC_PRE2_LSB +: PRE_W]),
        .src_sel_i(gctrl[`TMC_GC_SRC2_LSB +: 2]),
        .ext_src_i(tb2_ext_i),
        .angle_tick_i(angle_tick_i),
        .count_o(tb2),
        .tick_o(tick2)
    );

    assign ch_hit = adr[AW-1] && (adr[1:0] == 2'h0);
    assign ch_idx = adr[9:5];
    assign ch_word = adr[4:2];
    assign gctrl_m = tmc_merge({13'h0000, gctrl}, wb_dat_i, wb_sel_i);

    // Global control register
    always @(posedge mclk_i) begin
        if (sys_rst_i) begin
            gctrl <= `TMC_GCTRL_RST;
        end else if (wr_stb && adr == `TMC_OFF_GCTRL) begin
            gctrl <= gctrl_m[18:0];
        end
    end

    // One generated slice per channel
    genvar g;
    generate
        for (g = 0; g < NCH; g = g + 1) begin : g_ch
            reg [13:0] ctrl;
            reg [CNT_W-1:0] mat_a;
            reg [CNT_W-1:0] mat_b;
            reg [CNT_W-1:0] cap_a;
            reg [CNT_W-1:0] cap_b;
            reg arm_a;
            reg arm_b;
            reg flg_a;
            reg flg_b;
            reg svc;
            reg pin;
            reg pend;
            reg [1:0] pend_act;
            reg in_d;
            reg next_pin;
            wire [5:0] mi;
            wire me_wr;
            wire [CNT_W-1:0] cnt_a;
            wire [CNT_W-1:0] cnt_b;
            wire edge_in;
            wire raw_a;
            wire raw_b;
            wire ev_a;
            wire ev_b;
            wire svc_set;
            wire rearm;
            wire [1:0] force_act;
            wire ctrl_wr;
            wire lock;
            wire [5:0] mi_wr;
            wire [31:0] wr_m;

            assign mi = tmc_mode_info(ctrl[`TMC_CC_MODE_LSB +: 4]);
            assign me_wr = wr_stb && ch_hit && ({27'h0000000, ch_idx} == g);
            assign cnt_a = ctrl[`TMC_CC_TBSEL_A] ? tb2 : tb1;
            assign cnt_b = ctrl[`TMC_CC_TBSEL_B] ? tb2 : tb1;
            assign edge_in = ch_in_i[g] ^ in_d;
            // Full-width compare, or an input edge, while the unit is armed
            assign raw_a = arm_a && ((ctrl[`TMC_CC_MEN_A] && cnt_a == mat_a) ||
                (ctrl[`TMC_CC_EDGE_A] && edge_in));
            assign raw_b = arm_b && ((ctrl[`TMC_CC_MEN_B] && cnt_b == mat_b) ||
                (ctrl[`TMC_CC_EDGE_B] && edge_in));
            // First unit is stopped by the second under blocking and match-two
            assign ev_a = raw_a && !((mi[1] || mi[3]) && flg_b);
            // Second unit: not in single modes, waits for A when ordered or match-two
            assign ev_b = raw_b && !mi[0] && !((mi[2] || mi[3]) && !flg_a) &&
                !(mi[1] && (flg_a || ev_a)) && !(mi[3] && ev_a);
            // Double and both-match wait for both; match-two only on B
            assign svc_set = mi[4] ? ((flg_a || ev_a) && (flg_b || ev_b) && (ev_a || ev_b)) :
                (mi[3] ? ev_b : (ev_a || ev_b));
            assign rearm = me_wr && ch_word == `TMC_CW_STAT && wb_sel_i[0] && wb_dat_i[`TMC_ST_SVC];
            assign ctrl_wr = me_wr && ch_word == `TMC_CW_CTRL;
            assign force_act = (ctrl_wr && wb_sel_i[1]) ?
                wb_dat_i[`TMC_CC_FORCE_LSB +: 2] : `TMC_ACT_NONE;
            // A write that enters the interlocked mode also holds back its own force
            assign mi_wr = tmc_mode_info(wb_dat_i[`TMC_CC_MODE_LSB +: 4]);
            assign lock = (ctrl_wr && wb_sel_i[0]) ? mi_wr[5] : mi[5];
            // Byte-lane merge against the word being written
            assign wr_m = tmc_merge((ch_word == `TMC_CW_CTRL) ? {18'h00000, ctrl} :
                ((ch_word == `TMC_CW_MATCH_A) ? {8'h00, mat_a} : {8'h00, mat_b}), wb_dat_i, wb_sel_i);

            // Pin update: immediate force, then unit A, then unit B
            always @* begin
                next_pin = pin;
                if (!lock) begin
                    next_pin = tmc_apply(next_pin, force_act);
                end
                if (ev_a) begin
                    next_pin = tmc_apply(next_pin, ctrl[`TMC_CC_ACT_A_LSB +: 2]);
                    if (mi[5] && pend) begin
                        next_pin = tmc_apply(next_pin, pend_act);
                    end
                end
                if (ev_b) begin
                    next_pin = tmc_apply(next_pin, ctrl[`TMC_CC_ACT_B_LSB +: 2]);
                end
            end

            // Channel registers written by the engine
            always @(posedge mclk_i) begin
                if (sys_rst_i) begin
                    ctrl <= `TMC_CCTRL_RST;
                    mat_a <= {CNT_W{1'b0}};
                    mat_b <= {CNT_W{1'b0}};
                end else if (me_wr) begin
                    case (ch_word)
                        `TMC_CW_CTRL: ctrl <= wr_m[13:0];
                        `TMC_CW_MATCH_A: mat_a <= wr_m[CNT_W-1:0];
                        `TMC_CW_MATCH_B: mat_b <= wr_m[CNT_W-1:0];
                        default: ctrl <= ctrl;
                    endcase
                end
            end

            // Units, captures, service request and pin
            always @(posedge mclk_i) begin
                if (sys_rst_i) begin
                    cap_a <= {CNT_W{1'b0}};
                    cap_b <= {CNT_W{1'b0}};
                    arm_a <= 1'b1;
                    arm_b <= 1'b1;
                    flg_a <= 1'b0;
                    flg_b <= 1'b0;
                    svc <= 1'b0;
                    pin <= 1'b0;
                    pend <= 1'b0;
                    pend_act <= `TMC_ACT_NONE;
                    in_d <= 1'b0;
                end else begin
                    in_d <= ch_in_i[g];
                    pin <= next_pin;
                    if (ev_a) begin
                        cap_a <= cnt_a;
                    end
                    if (ev_b) begin
                        cap_b <= cnt_b;
                    end
                    // Each unit fires once; a third event needs a rearm
                    arm_a <= (arm_a && !ev_a) || rearm;
                    arm_b <= (arm_b && !ev_b) || rearm;
                    // Events win over a clear in the same cycle
                    flg_a <= ev_a || (flg_a && !rearm);
                    flg_b <= ev_b || (flg_b && !rearm);
                    svc <= svc_set || (svc && !rearm);
                    // Interlocked force waits for the next A match
                    if (lock && force_act != `TMC_ACT_NONE) begin
                        pend <= 1'b1;
                        pend_act <= force_act;
                    end else if (ev_a) begin
                        pend <= 1'b0;
                    end
                end
            end

            assign all_ctrl[g*14 +: 14] = ctrl;
            assign all_mat_a[g*CNT_W +: CNT_W] = mat_a;
            assign all_mat_b[g*CNT_W +: CNT_W] = mat_b;
            assign all_cap_a[g*CNT_W +: CNT_W] = cap_a;
            assign all_cap_b[g*CNT_W +: CNT_W] = cap_b;
            assign all_stat[g*6 +: 6] = {arm_b, arm_a, pin, flg_b, flg_a, svc};
            assign ch_out_o[g] = pin;
            assign svc_req_o[g] = svc;
        end
    endgenerate

    // Read mux; unmapped words and channels beyond the array read zero
    always @* begin
        rd_data = 32'h00000000;
        if (ch_hit) begin
            if ({27'h0000000, ch_idx} < NCH) begin
                case (ch_word)
                    `TMC_CW_CTRL: rd_data = {18'h00000, all_ctrl[ch_idx*14 +: 14]};
                    `TMC_CW_MATCH_A: rd_data = {8'h00, all_mat_a[ch_idx*CNT_W +: CNT_W]};
                    `TMC_CW_MATCH_B: rd_data = {8'h00, all_mat_b[ch_idx*CNT_W +: CNT_W]};
                    `TMC_CW_CAPT_A: rd_data = {8'h00, all_cap_a[ch_idx*CNT_W +: CNT_W]};
                    `TMC_CW_CAPT_B: rd_data = {8'h00, all_cap_b[ch_idx*CNT_W +: CNT_W]};
                    `TMC_CW_STAT: rd_data = {26'h0000000, all_stat[ch_idx*6 +: 6]};
                    default: rd_data = 32'h00000000;
                endcase
            end
        end else begin
            case (adr)
                `TMC_OFF_GCTRL: rd_data = {13'h0000, gctrl};
                `TMC_OFF_TB1: rd_data = {8'h00, tb1};
                `TMC_OFF_TB2: rd_data = {8'h00, tb2};
                default: rd_data = 32'h00000000;
            endcase
        end
    end

endmodule // tmc_channels

/* File: tmc_engine_model.sv */
// Service engine timing model: says when a pending request may be rearmed
`timescale 1ns/100ps
module tmc_engine_model #(parameter NCH = 32, parameter SVC_CYC = 10) (
    input wire mclk_i,
    input wire sys_rst_i,
    input wire [NCH-1:0] svc_req_i,
    output logic rearm_o
);
    int cnt;
    // Engine never turns a request round faster than its minimum service time
    always @(posedge mclk_i) begin
        if (sys_rst_i || svc_req_i == '0) begin
            cnt <= 0;
            rearm_o <= 1'b0;
        end else if (cnt < SVC_CYC) begin
            cnt <= cnt + 1;
        end else begin
            rearm_o <= 1'b1;
        end
    end
endmodule // tmc_engine_model

/* File: tmc_channels_checker.sv */
// Checker of bus handshake, service flags and immediate pin actions
`timescale 1ns/100ps
module tmc_channels_checker #(parameter NCH = 32, parameter AW = 11) (
    input wire mclk_i,
    input wire sys_rst_i,
    input wire wb_cyc_i,
    input wire wb_stb_i,
    input wire wb_we_i,
    input wire [AW-1:0] wb_adr_i,
    input wire [3:0] wb_sel_i,
    input wire [31:0] wb_dat_i,
    input wire [31:0] wb_dat_o,
    input wire wb_ack_o,
    input wire [NCH-1:0] ch_out_o,
    input wire [NCH-1:0] svc_req_o
);
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (sys_rst_i);
    // Bus answers every access one cycle later, for one cycle only
    a_ack_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("ack missing after request");
    a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    a_ack_cause: assert property ($rose(wb_ack_o) |-> $past(wb_cyc_i && wb_stb_i))
        else $error("ack without request");
    a_dat_hold: assert property ($changed(wb_dat_o) && !$past(sys_rst_i) |-> wb_ack_o && !wb_we_i)
        else $error("read data moved outside a read");
    // Requests are sticky; only a bus write may drop one, since the engine must rearm
    a_svc_sticky: assert property ((|($past(svc_req_o) & ~svc_req_o)) && !$past(sys_rst_i)
        |-> $past(wb_ack_o && wb_we_i)) else $error("service request lost");
    a_quiet_reset: assert property ($fell(sys_rst_i) |-> svc_req_o == '0 && ch_out_o == '0 && !wb_ack_o)
        else $error("outputs active after reset");
    // Immediate actions on channel 0 outside the interlocked mode
    a_force_high: assert property (wb_ack_o && wb_we_i && wb_adr_i == 11'h400 && wb_sel_i[1:0] == 2'h3
        && wb_dat_i[15:14] == 2'h1 && wb_dat_i[3:0] != 4'h1 |=> ch_out_o[0]) else $error("force high");
    a_force_low: assert property (wb_ack_o && wb_we_i && wb_adr_i == 11'h400 && wb_sel_i[1:0] == 2'h3
        && wb_dat_i[15:14] == 2'h2 && wb_dat_i[3:0] != 4'h1 |=> !ch_out_o[0]) else $error("force low");
endmodule // tmc_channels_checker
bind tmc_channels tmc_channels_checker #(.NCH(NCH), .AW(AW)) chk_inst (.mclk_i, .sys_rst_i, .wb_cyc_i,
    .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .ch_out_o, .svc_req_o);

/* File: testbench.sv */
// Self-checking bench of the timer channel array
`timescale 1ns/100ps
`define CHK(n, e, v) begin check_count++; if ((v) !== (e)) begin err_count++; $display("ERROR %s exp %h got %h", n, e, v); end end
module testbench;
    localparam NCH = 4;
    localparam logic [9:0] FC = 10'h0BD;
    localparam logic [4:0] FE = 5'h05;
    logic mclk_i = 1'b0;
    logic sys_rst_i = 1'b1;
    logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0, angle_tick_i = 1'b0;
    logic [10:0] wb_adr_i = 11'h000;
    logic [31:0] wb_dat_i = 32'h00000000;
    logic [NCH-1:0] ch_in_i = 4'h0;
    wire [31:0] wb_dat_o;
    wire wb_ack_o, rearm;
    wire [NCH-1:0] ch_out_o, svc_req_o;
    logic [31:0] eq[$], mq[$], q, cap, lfsr = 32'h765B;
    logic [23:0] m;
    logic [15:0] e;
    int err_count = 0, check_count = 0, tmo = 0, tb_cyc = 0, hi_len = 0, pw = 0, k;
    logic [15:0] tbl [12] = '{16'h111B, 16'h021B, 16'h221B, 16'h320A, 16'h4217, 16'h5207,
        16'h6207, 16'h7207, 16'h8207, 16'h9207, 16'hA207, 16'hB207};
    tmc_channels #(.NCH(NCH)) tmc_channels_inst (.mclk_i, .sys_rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i,
        .wb_adr_i, .wb_sel_i(4'hF), .wb_dat_i, .wb_dat_o, .wb_ack_o, .ch_in_i, .tb2_ext_i(1'b0),
        .angle_tick_i, .ch_out_o, .svc_req_o);
    tmc_engine_model #(.NCH(NCH)) tmc_engine_model_inst (.mclk_i, .sys_rst_i, .svc_req_i(svc_req_o),
        .rearm_o(rearm));
    always #5 mclk_i = ~mclk_i;
    function automatic logic [31:0] nxt(input logic [31:0] s);
        nxt = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task automatic end_sim;
        if (err_count == 0 && check_count > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    // Classic single cycle: hold everything until ack is sampled high
    task automatic wb(input logic we, input logic [10:0] a, input logic [31:0] d);
        @(posedge mclk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= a;
        wb_dat_i <= d;
        do @(posedge mclk_i); while (wb_ack_o !== 1'b1);
        q = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        wb_we_i <= 1'b0;
    endtask
    // A read notes its masked expectation for the watcher
    task automatic rd(input logic [10:0] a, input logic [31:0] x, input logic [31:0] msk);
        eq.push_back(x & msk);
        mq.push_back(msk);
        wb(1'b0, a, 32'h00000000);
    endtask
    // Watcher of read answers, pulse width on channel 1, and the hang limit
    always @(posedge mclk_i) begin
        tmo <= tmo + 1;
        tb_cyc <= sys_rst_i ? 0 : tb_cyc + 1;
        hi_len <= (ch_out_o[1] === 1'b1) ? hi_len + 1 : 0;
        if (hi_len != 0 && ch_out_o[1] === 1'b0) pw <= hi_len;
        if (wb_ack_o === 1'b1 && wb_we_i === 1'b0) begin
            `CHK("read data", eq[0], wb_dat_o & mq[0])
            void'(eq.pop_front());
            void'(mq.pop_front());
        end
        if (tmo == 12000) begin
            err_count++;
            end_sim();
        end
    end
    initial begin
        repeat (8) @(posedge mclk_i);
        sys_rst_i <= 1'b0;
        // Reset values, unmapped place and a channel beyond the array
        rd(11'h000, 32'h00040000, 32'hFFFFFFFF);
        rd(11'h414, 32'h00000030, 32'h0000003F);
        rd(11'h100, 32'h00000000, 32'hFFFFFFFF);
        rd(11'h480, 32'h00000000, 32'hFFFFFFFF);
        // Immediate actions: high, toggle twice, low, none
        for (int i = 0; i < 5; i++) begin
            wb(1'b1, 11'h400, {16'h0000, FC[2*i +: 2], 14'h0000});
            @(negedge mclk_i);
            `CHK("forced pin", FE[i], ch_out_o[0])
        end
        // Narrowest pulse from adjacent matches; junk above bit 23 must not matter
        m = tb_cyc / 2 + 100;
        wb(1'b1, 11'h424, {8'hFF, m});
        wb(1'b1, 11'h428, {8'hFF, m + 24'h000001});
        wb(1'b1, 11'h420, 32'h0000324C);
        while (rearm !== 1'b1) @(posedge mclk_i);
        `CHK("pulse width", 2, pw)
        rd(11'h434, 32'h00000007, 32'h0000000F);
        wb(1'b1, 11'h434, 32'h00000001);
        rd(11'h434, 32'h00000030, 32'h0000003F);
        // Mode table on channel 3: service at mid point and final status
        for (int i = 0; i < 12; i++) begin
            e = tbl[i];
            m = tb_cyc / 2 + 100;
            wb(1'b1, 11'h464, {8'h00, m});
            wb(1'b1, 11'h468, {8'h00, m + 24'h000064});
            wb(1'b1, 11'h474, 32'h00000001);
            wb(1'b1, 11'h460, {16'h0000, e[9:8], 4'hC, (e[15:12] == 4'h1) ? 4'h0 : 4'hF, 2'h0, e[15:12]});
            @(negedge mclk_i);
            `CHK("start pin", 1'b0, ch_out_o[3])
            repeat (300) @(posedge mclk_i);
            `CHK("mid service", e[4], svc_req_o[3])
            repeat (200) @(posedge mclk_i);
            rd(11'h474, {28'h0000000, e[3:0]}, 32'h0000000F);
        end
        // Ordered capture on the angle-driven counter, random step count
        wb(1'b1, 11'h000, 32'h00060000);
        wb(1'b1, 11'h440, 32'h00000C38);
        lfsr = nxt(lfsr);
        ch_in_i <= {lfsr[3], 1'b1, lfsr[1:0]};
        repeat (3) @(posedge mclk_i);
        `CHK("service after one edge", 1'b0, svc_req_o[2])
        // Counter two stands still until the first angle step
        rd(11'h008, 32'h00000000, 32'h00000000);
        cap = q;
        rd(11'h44C, cap, 32'h00FFFFFF);
        k = lfsr[6:4] + 1;
        repeat (k) begin
            @(posedge mclk_i) angle_tick_i <= 1'b1;
            @(posedge mclk_i) angle_tick_i <= 1'b0;
            repeat (2) @(posedge mclk_i);
        end
        @(posedge mclk_i) ch_in_i[2] <= 1'b0;
        repeat (3) @(posedge mclk_i);
        `CHK("service after two edges", 1'b1, svc_req_o[2])
        rd(11'h450, cap + k, 32'h00FFFFFF);
        end_sim();
    end
endmodule // testbench
